// ==== switch_reset_regs.svh ====
`ifndef SWITCH_RESET_REGS_SVH
`define SWITCH_RESET_REGS_SVH

// ==========================================
// Register offsets (byte addresses)
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define DSBR_OFS 12'h008
`define STICKY_OFS 12'h00C
`define SCRATCH_OFS 12'h010

// ==========================================
// Control register fields
`define CTRL_SOFT_BIT 0
`define CTRL_HOT_BIT 1
`define CTRL_USBR_BIT 2

// ==========================================
// Port layout
`define NPORTS 16
`define UP_PORT 0
`define UP_MASK 16'h0001

// ==========================================
// Switch mode strap codes
`define MODE_NORMAL_CODE 4'h0
`define MODE_EEPROM_CODE 4'h1

// ==========================================
// Reset values
`define STRAP_RST 4'h0
`define STICKY_RST 32'h00000000
`define SCRATCH_RST 32'h00000000
`define DSBR_RST 16'h0000

`endif

// ==== switch_reset_pkg.sv ====
package switch_reset_pkg;
`include "switch_reset_regs.svh"

	// ==========================================
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_WAIT = 6'h01,
		ST_LATCH = 6'h02,
		ST_DECODE = 6'h04,
		ST_PHY = 6'h08,
		ST_TRAIN = 6'h10,
		ST_RUN = 6'h20
	} seq_state_t;

	// Decoded operating mode
	typedef enum logic [1:0] {
		OPM_NORMAL = 2'h0,
		OPM_EEPROM = 2'h1,
		OPM_RESERVED = 2'h2
	} op_mode_t;

	// Status register layout
	typedef struct packed {
		logic [17:0] zero;
		logic eeprom;
		logic rsvd;
		logic [3:0] mode;
		logic cause_pin;
		logic cold;
		seq_state_t st;
	} status_t;

	// Strap value to operating mode
	function automatic op_mode_t decode_mode(input logic [3:0] code);
		op_mode_t m;
		m = OPM_RESERVED;
		if (code == `MODE_NORMAL_CODE) begin
			m = OPM_NORMAL;
		end else if (code == `MODE_EEPROM_CODE) begin
			m = OPM_EEPROM;
		end
		return m;
	endfunction

endpackage

// ==== pin_sync.sv ====
`timescale 1ns/1ps
// ==========================================
// Two-flop synchroniser for pin levels
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // First stage, read only by q

	// Two stages, both reset to zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ==== strap_latch.sv ====
`timescale 1ns/1ps
`include "switch_reset_regs.svh"
// ==========================================
// Boot strap holding register
module strap_latch
	import switch_reset_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Capture
	input wire logic load,
	input wire logic [3:0] d,
	output logic [3:0] q
);
	// Keeps the last capture until the next load
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= `STRAP_RST;
		end else if (load) begin
			q <= d;
		end
	end
endmodule

// ==== switch_reset_sequencer.sv ====
`timescale 1ns/1ps
`include "switch_reset_regs.svh"
module switch_reset_sequencer
	import switch_reset_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Board pins
	input wire logic BOARD_RESET_PIN_N,
	input wire logic [3:0] SWITCH_MODE_STRAPS,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Hot reset request from upstream link
	input wire logic HOT_RST_REQ,
	// PLL and transceiver bring-up
	output logic PHY_INIT_REQ,
	input wire logic PHY_INIT_DONE,
	// Sequence results
	output logic CORE_RST_N,
	output logic LINK_TRAIN_START,
	output logic [3:0] SWITCH_MODE,
	output logic EEPROM_INIT_EN,
	output logic MODE_RESERVED,
	output logic COLD_RESET,
	// Bridge and link hot resets
	output logic [`NPORTS-1:0] HOT_RST,
	output logic [`NPORTS-1:0] LINK_HOT_RST
);
	// ==========================================
	// Declarations
	logic pin_s; // Synchronised reset pin level
	logic [3:0] straps_s; // Synchronised straps
	logic [3:0] latched; // Held strap value
	logic strap_load; // Capture strobe
	seq_state_t st_r; // Sequencer state
	logic cause_pin_r; // Current reset came from pin
	logic power_up_r; // No sequence has reached the latch step since power-on
	logic soft_r; // Soft fundamental reset bit
	logic hot_r; // Hot reset pulse from software
	logic usbr_r; // Upstream secondary bus reset
	logic [`NPORTS-1:0] dsbr_r; // Downstream bus resets
	logic [31:0] sticky_r; // Sticky scratch
	logic [31:0] scratch_r; // Non-sticky scratch
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic phy_req_r;
	logic core_rst_n_r;
	logic train_r;
	logic [3:0] mode_r;
	logic eeprom_r;
	logic rsvd_r;
	logic cold_r;
	logic [`NPORTS-1:0] hot_rst_r;
	logic [`NPORTS-1:0] link_hot_r;
	logic acc; // First access cycle
	logic wr; // Write commit edge
	logic fund; // Fundamental reset in force
	logic hot_p; // Hot reset event
	op_mode_t dec; // Decoded latched mode
	status_t stat; // Status word

	// ==========================================
	// Pin synchronisers
	// two-flop reset pin
	pin_sync #(.W(1)) u_pin_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d(BOARD_RESET_PIN_N),
		.q(pin_s)
	);

	// Straps arrive asynchronously too
	pin_sync #(.W(4)) u_strap_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d(SWITCH_MODE_STRAPS),
		.q(straps_s)
	);

	assign strap_load = (st_r == ST_LATCH) && cause_pin_r;

	strap_latch u_strap_latch (
		.clk(CLK),
		.rst_n(RST_N),
		.load(strap_load),
		.d(straps_s),
		.q(latched)
	);

	// ==========================================
	// Common terms
	assign acc = PSEL && PENABLE && !pready_r;
	assign wr = PSEL && PENABLE && pready_r && PWRITE;
	assign fund = (st_r == ST_WAIT);
	assign hot_p = hot_r || HOT_RST_REQ;
	assign dec = decode_mode(latched);

	// Status word
	always_comb begin
		stat = '0;
		stat.eeprom = eeprom_r;
		stat.rsvd = rsvd_r;
		stat.mode = mode_r;
		stat.cause_pin = cause_pin_r;
		stat.cold = cold_r;
		stat.st = st_r;
	end

	// ==========================================
	// Reset sequencer
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= ST_WAIT;
			cause_pin_r <= 1'b1;
		end else if (!pin_s) begin
			st_r <= ST_WAIT;
			cause_pin_r <= 1'b1;
		end else if (soft_r) begin
			st_r <= ST_WAIT;
			cause_pin_r <= 1'b0;
		end else begin
			unique case (st_r)
				ST_WAIT: begin
					st_r <= ST_LATCH;
				end
				ST_LATCH: begin
					st_r <= ST_DECODE;
				end
				ST_DECODE: begin
					st_r <= ST_PHY;
				end
				ST_PHY: begin
					if (PHY_INIT_DONE) begin
						st_r <= ST_TRAIN;
					end
				end
				ST_TRAIN: begin
					st_r <= ST_RUN;
				end
				ST_RUN: begin
					st_r <= ST_RUN;
				end
				default: begin
					st_r <= ST_WAIT;
				end
			endcase
		end
	end

	// ==========================================
	// Cold or warm classification
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			power_up_r <= 1'b1;
			cold_r <= 1'b0;
		end else if (st_r == ST_LATCH) begin
			cold_r <= cause_pin_r && power_up_r;
			power_up_r <= 1'b0;
		end
	end

	// ==========================================
	// Mode decode outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_r <= `STRAP_RST;
			eeprom_r <= 1'b0;
			rsvd_r <= 1'b0;
		end else if (st_r == ST_DECODE) begin
			mode_r <= latched;
			eeprom_r <= (dec == OPM_EEPROM);
			rsvd_r <= (dec == OPM_RESERVED);
		end
	end

	// ==========================================
	// Bring-up handshakes and core reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			phy_req_r <= 1'b0;
			train_r <= 1'b0;
			core_rst_n_r <= 1'b0;
		end else begin
			phy_req_r <= (st_r == ST_DECODE) || ((st_r == ST_PHY) && !PHY_INIT_DONE);
			train_r <= (st_r == ST_TRAIN);
			core_rst_n_r <= ((st_r == ST_TRAIN) || (st_r == ST_RUN)) && pin_s && !soft_r;
		end
	end

	// ==========================================
	// Control register and bus resets
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			soft_r <= 1'b0;
			hot_r <= 1'b0;
			usbr_r <= 1'b0;
			dsbr_r <= `DSBR_RST;
		end else begin
			soft_r <= wr && (PADDR == `CTRL_OFS) && PWDATA[`CTRL_SOFT_BIT];
			hot_r <= wr && (PADDR == `CTRL_OFS) && PWDATA[`CTRL_HOT_BIT];
			if (fund || hot_p) begin
				// Bus reset bits are not sticky
				usbr_r <= 1'b0;
				dsbr_r <= `DSBR_RST;
			end else if (wr && (PADDR == `CTRL_OFS)) begin
				usbr_r <= PWDATA[`CTRL_USBR_BIT];
			end else if (wr && (PADDR == `DSBR_OFS)) begin
				dsbr_r <= PWDATA[`NPORTS-1:0];
			end
		end
	end

	// ==========================================
	// Sticky and non-sticky storage
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sticky_r <= `STICKY_RST;
		end else if (fund) begin
			sticky_r <= `STICKY_RST;
		end else if (wr && (PADDR == `STICKY_OFS)) begin
			sticky_r <= PWDATA;
		end
	end

	// Cleared by either reset kind
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			scratch_r <= `SCRATCH_RST;
		end else if (fund || hot_p) begin
			scratch_r <= `SCRATCH_RST;
		end else if (wr && (PADDR == `SCRATCH_OFS)) begin
			scratch_r <= PWDATA;
		end
	end

	// ==========================================
	// Bridge and link hot reset outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hot_rst_r <= '1;
			link_hot_r <= '0;
		end else begin
			hot_rst_r <= {`NPORTS{fund || hot_p}} | ({`NPORTS{usbr_r}} & ~`UP_MASK);
			link_hot_r <= dsbr_r & ~`UP_MASK;
		end
	end

	// ==========================================
	// APB slave, one wait state
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= acc;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
			if (acc) begin
				unique case (PADDR)
					`CTRL_OFS: begin
						prdata_r <= PWRITE ? 32'h0 : {29'h0, usbr_r, hot_r, soft_r};
					end
					`STATUS_OFS: begin
						prdata_r <= PWRITE ? 32'h0 : stat;
					end
					`DSBR_OFS: begin
						prdata_r <= PWRITE ? 32'h0 : {16'h0000, dsbr_r};
					end
					`STICKY_OFS: begin
						prdata_r <= PWRITE ? 32'h0 : sticky_r;
					end
					`SCRATCH_OFS: begin
						prdata_r <= PWRITE ? 32'h0 : scratch_r;
					end
					// Unmapped address
					default: begin
						pslverr_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// ==========================================
	// Output wiring
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign PHY_INIT_REQ = phy_req_r;
	assign CORE_RST_N = core_rst_n_r;
	assign LINK_TRAIN_START = train_r;
	assign SWITCH_MODE = mode_r;
	assign EEPROM_INIT_EN = eeprom_r;
	assign MODE_RESERVED = rsvd_r;
	assign COLD_RESET = cold_r;
	assign HOT_RST = hot_rst_r;
	assign LINK_HOT_RST = link_hot_r;

	// ==========================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sticky_fund_a: assert property (fund |=> sticky_r == 32'h0)
		else $error("sticky field survived fundamental reset");
	sticky_hot_a: assert property ((hot_p && !fund && !wr) |=> $stable(sticky_r) && scratch_r == 32'h0)
		else $error("hot reset disturbed sticky field");
	usbr_spare_a: assert property ((usbr_r && !fund && !hot_p) |=> HOT_RST == ~`UP_MASK)
		else $error("upstream bus reset pattern wrong");
	dsbr_link_a: assert property ((st_r == ST_RUN) |=> LINK_HOT_RST == ($past(dsbr_r) & ~`UP_MASK))
		else $error("downstream link reset mismatch");
	cold_class_a: assert property ((st_r == ST_LATCH) |=> COLD_RESET == $past(cause_pin_r && power_up_r))
		else $error("cold or warm classification wrong");
	pin_restart_a: assert property (!pin_s |=> st_r == ST_WAIT && cause_pin_r)
		else $error("pin reset did not restart sequence");
	soft_start_a: assert property ((soft_r && pin_s) |=> st_r == ST_WAIT && !cause_pin_r && !soft_r)
		else $error("soft reset did not start warm reset");
	wait_hold_a: assert property ((st_r != ST_WAIT) |-> $past(pin_s))
		else $error("sequence left first step with pin asserted");
	strap_take_a: assert property (strap_load |=> latched == $past(straps_s))
		else $error("straps not captured at negation");
	strap_keep_a: assert property ((st_r == ST_LATCH && !cause_pin_r) |=> $stable(latched))
		else $error("straps resampled on soft reset");
	mode_dec_a: assert property ((st_r == ST_DECODE) |=> SWITCH_MODE == $past(latched)
		&& EEPROM_INIT_EN == ($past(latched) == `MODE_EEPROM_CODE))
		else $error("mode decode wrong");
	mode_rsvd_a: assert property ((st_r == ST_DECODE && latched[3:1] != 3'h0) |=> MODE_RESERVED)
		else $error("reserved code not flagged");
	phy_first_a: assert property (LINK_TRAIN_START |-> $past(PHY_INIT_DONE, 2))
		else $error("training started before PHY done");
	train_go_a: assert property ((st_r == ST_TRAIN && pin_s && !soft_r) |=> st_r == ST_RUN ##0 LINK_TRAIN_START)
		else $error("sequencer waited on training");
	sync_use_a: assert property ($fell(pin_s) |=> st_r == ST_WAIT)
		else $error("synchronised pin not honoured");

	cold_run_c: cover property ((st_r == ST_LATCH && power_up_r) ##[1:50] st_r == ST_RUN);
	soft_run_c: cover property (soft_r ##[1:50] (st_r == ST_RUN && !cause_pin_r));
	usbr_c: cover property (usbr_r ##1 HOT_RST == ~`UP_MASK);
	eeprom_c: cover property (EEPROM_INIT_EN && LINK_TRAIN_START);
endmodule

// ==== board_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Board reset source, strap pins and transceiver stand-in
module board_model (
	// Clock
	input wire logic clk,
	// Commands from the bench
	input wire logic hold_n,
	input wire logic [3:0] code,
	input wire logic brk,
	input wire logic [3:0] lag,
	// Device side
	input wire logic phy_req,
	output logic pin_n,
	output logic [3:0] straps,
	output logic phy_done
);
	logic [3:0] cnt; // Cycles since init was asked for
	initial begin
		pin_n = 1'b0;
		straps = 4'h0;
		phy_done = 1'b0;
		cnt = 4'h0;
	end
	// Reset pin follows the bench command
	always @(posedge clk) begin
		pin_n <= hold_n;
	end
	always @(posedge clk) begin
		if (!hold_n || brk) begin
			straps <= code;
		end
	end
	// Lock reported after lag cycles, dropped with the request
	always @(posedge clk) begin
		if (!phy_req) begin
			cnt <= 4'h0;
			phy_done <= 1'b0;
		end else if (cnt == lag) begin
			phy_done <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// ==== switch_reset_sequencer_tb.sv ====
`timescale 1ns/1ps
`include "switch_reset_regs.svh"
// ==========================================
// Bench top
module switch_reset_sequencer_tb;
	import switch_reset_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, perr, phy_req, phy_done, core_rst_n, train, eeprom, rsvd, cold, pin_n;
	logic hot_req = 1'b0;
	logic hold_n = 1'b0;
	logic brk = 1'b0;
	logic [3:0] code = 4'h0;
	logic [3:0] lag = 4'h0;
	logic [3:0] mode, straps;
	logic [15:0] hot, link_hot;
	int errors = 0;
	int n_compared = 0;
	typedef struct {logic [3:0] c; logic ee; logic rs;} row_t;
	row_t rows [4] = '{'{4'h0, 1'b0, 1'b0}, '{4'h1, 1'b1, 1'b0}, '{4'h2, 1'b0, 1'b1}, '{4'hF, 1'b0, 1'b1}};

	// Clock
	always #12.5 clk = ~clk;

	// ==========================================
	// Design and board
	switch_reset_sequencer DUT (.CLK(clk), .RST_N(rst_n), .BOARD_RESET_PIN_N(pin_n),
		.SWITCH_MODE_STRAPS(straps), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HOT_RST_REQ(hot_req),
		.PHY_INIT_REQ(phy_req), .PHY_INIT_DONE(phy_done), .CORE_RST_N(core_rst_n),
		.LINK_TRAIN_START(train), .SWITCH_MODE(mode), .EEPROM_INIT_EN(eeprom),
		.MODE_RESERVED(rsvd), .COLD_RESET(cold), .HOT_RST(hot), .LINK_HOT_RST(link_hot));
	board_model BRD (.clk(clk), .hold_n(hold_n), .code(code), .brk(brk), .lag(lag),
		.phy_req(phy_req), .pin_n(pin_n), .straps(straps), .phy_done(phy_done));

	// ==========================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		perr = pslverr;
		if (k >= 50) errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for training start, noting transceiver init before it
	task automatic wait_train();
		int k;
		logic seen;
		seen = 1'b0;
		k = 0;
		while (train !== 1'b1 && k < 300) begin
			@(posedge clk);
			#1;
			if (phy_req === 1'b1) seen = 1'b1;
			k++;
		end
		chk("phy_before_train", 32'h1, {31'h0, seen});
		chk("train_start", 32'h1, {31'h0, train});
		chk("core_rst_n", 32'h1, {31'h0, core_rst_n});
	endtask
	// Pin held low for a number of cycles, then released
	task automatic pin_low(input logic [3:0] c, input int n);
		@(posedge clk);
		hold_n <= 1'b0;
		code <= c;
		repeat (n) @(posedge clk);
		hold_n <= 1'b1;
	endtask
	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#(25 * 20000);
		errors++;
		end_of_test();
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		chk("hot_in_reset", 32'hFFFF, {16'h0, hot});
		rst_n <= 1'b1;
		hold_n <= 1'b1;
		wait_train();
		chk("cold_power_up", 32'h1, {31'h0, cold});
		$display("power-up done");
		// Table of strap codes with prompt and slow transceivers
		foreach (rows[i]) begin
			lag <= 4'(i * 4);
			pin_low(rows[i].c, 4);
			wait_train();
			chk("mode", {28'h0, rows[i].c}, {28'h0, mode});
			chk("eeprom", {31'h0, rows[i].ee}, {31'h0, eeprom});
			chk("reserved", {31'h0, rows[i].rs}, {31'h0, rsvd});
			chk("warm_pin", 32'h0, {31'h0, cold});
			$display("row %0d done", i);
		end
		// Hold in first step while the pin stays low
		pin_low(4'hF, 30);
		apb(1'b0, `STATUS_OFS, 32'h0);
		chk("status_wait", 32'h01, {26'h0, rd[5:0]});
		chk("core_held", 32'h0, {31'h0, core_rst_n});
		wait_train();
		$display("hold done");
		// Hot reset keeps sticky, clears the rest
		apb(1'b1, `STICKY_OFS, 32'hA5A50001);
		apb(1'b1, `SCRATCH_OFS, 32'h00001234);
		@(posedge clk);
		hot_req <= 1'b1;
		@(posedge clk);
		hot_req <= 1'b0;
		#1;
		chk("hot_all", 32'hFFFF, {16'h0, hot});
		apb(1'b0, `STICKY_OFS, 32'h0);
		chk("sticky_kept", 32'hA5A50001, rd);
		apb(1'b0, `SCRATCH_OFS, 32'h0);
		chk("scratch_clr", 32'h0, rd);
		// Hot reset from the control register bit
		apb(1'b1, `SCRATCH_OFS, 32'h00005678);
		apb(1'b1, `CTRL_OFS, 32'h2);
		@(posedge clk);
		#1;
		chk("hot_bit_all", 32'hFFFF, {16'h0, hot});
		apb(1'b0, `SCRATCH_OFS, 32'h0);
		chk("hot_bit_scratch", 32'h0, rd);
		// Upstream and downstream bus resets
		apb(1'b1, `CTRL_OFS, 32'h4);
		repeat (2) @(posedge clk);
		chk("usbr", 32'hFFFE, {16'h0, hot});
		apb(1'b1, `CTRL_OFS, 32'h0);
		apb(1'b1, `DSBR_OFS, 32'h8005);
		repeat (2) @(posedge clk);
		chk("dsbr", 32'h8004, {16'h0, link_hot});
		apb(1'b1, `DSBR_OFS, 32'h0);
		$display("bus resets done");
		// Soft reset with the straps moved behind its back
		brk <= 1'b1;
		code <= 4'h1;
		lag <= 4'hF;
		apb(1'b1, `CTRL_OFS, 32'h1);
		apb(1'b0, `CTRL_OFS, 32'h0);
		chk("soft_clear", 32'h0, {31'h0, rd[0]});
		wait_train();
		brk <= 1'b0;
		chk("straps_kept", 32'hF, {28'h0, mode});
		chk("warm_soft", 32'h0, {31'h0, cold});
		apb(1'b0, `STICKY_OFS, 32'h0);
		chk("sticky_clr", 32'h0, rd);
		// Unmapped place
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, perr});
		chk("unmapped_data", 32'h0, rd);
		$display("soft reset done");
		// Power-on reset again in mid-run, pin left high
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("hot_rerun_reset", 32'hFFFF, {16'h0, hot});
		chk("core_rerun_reset", 32'h0, {31'h0, core_rst_n});
		@(posedge clk);
		rst_n <= 1'b1;
		wait_train();
		chk("cold_rerun", 32'h1, {31'h0, cold});
		chk("mode_rerun", 32'h1, {28'h0, mode});
		chk("eeprom_rerun", 32'h1, {31'h0, eeprom});
		$display("reset rerun done");
		end_of_test();
	end
endmodule
